// ---- hw/bcb_cfg_regs.sv ----
// Type-1 configuration header words 0Ch, 18h and the low half of 1Ch for a bridge with two
// secondary functions, plus the timers and the I/O window decode that these fields steer.
// Assumes all inputs are synchronous to the PCI clock and that the upper 16 I/O address bits
// come from a register outside this block.
//
// Function
// - An 8-bit writable cache line size in dwords ends write-and-invalidate lines and sizes prefetches.
// - Bits 15:8 at 0Ch hold the primary latency value that loads a counter when the bridge starts a frame.
// - Function 0 returns a read-only header type of 81h.
// - Function 1 returns a read-only header type of 01h.
// - Bits 7:0 at 18h hold a writable primary bus number.
// - Each function holds a writable secondary bus number in bits 15:8 at 18h.
// - Each function holds a writable subordinate bus number in bits 23:16 at 18h.
// - Bits 31:24 at 18h hold a secondary latency in clocks that times out unclaimed secondary accesses.
// - The low nibbles of the I/O base and limit bytes read as 1 to show 32-bit I/O.
// - I/O base bits 7:4 give window bottom bits 15:12 and its bits 11:0 are zero.
// - I/O limit bits 15:12 give window top bits 15:12 and its bits 11:0 are all ones.
// - Window bits 31:16 come from the separate upper I/O register, not from these bytes.
// - The window bounds decide whether an I/O transaction is forwarded.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns

module bcb_cfg_regs
    import bcb_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    // Configuration register port.
    input  wire bcb_cfg_req_t         cfg_req_in,
    output logic [31:0]               cfg_rdata_out,
    // Cache line use by the memory datapath.
    input  wire logic                 line_idx_valid_in,
    input  wire logic [7:0]           line_idx_in,
    output logic                      line_end_out,
    output logic [7:0]                prefetch_dwords_out,
    // Primary master latency timer.
    input  wire logic                 prim_frame_start_in,
    input  wire logic                 prim_frame_active_in,
    output logic                      prim_lat_expired_out,
    // Secondary unclaimed-access timers, one per function.
    input  wire logic [NUM_FUNC-1:0]  sec_access_start_in,
    input  wire logic [NUM_FUNC-1:0]  sec_claimed_in,
    output logic [NUM_FUNC-1:0]       sec_unclaimed_out,
    // I/O window decode.
    input  wire logic [15:0]          io_bot_upper_in [NUM_FUNC],
    input  wire logic [15:0]          io_top_upper_in [NUM_FUNC],
    input  wire bcb_io_req_t          io_req_in,
    output logic                      io_dec_valid_out,
    output logic [NUM_FUNC-1:0]       io_in_window_out
);

    // Byte merge under a lane enable, used for every writable byte.
    function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v,
                                          input logic en);
        merge8 = en ? new_v : old_v;
    endfunction : merge8

    // Write-data byte of a lane.
    function automatic logic [7:0] wbyte(input logic [31:0] d, input int lane);
        wbyte = d[8*lane +: 8];
    endfunction : wbyte

    // Shared fields.
    logic [7:0]      cls_ff;
    logic [7:0]      plat_ff;
    logic [7:0]      pbus_ff;
    // Per-function fields.
    bcb_func_regs_t  fregs_ff [NUM_FUNC];
    // A net, so that each field of a function may have its own continuous assignment.
    wire bcb_func_regs_t nxt_fregs [NUM_FUNC];
    // Read path.
    logic [31:0]     rd_data_ff;
    // Primary latency counter.
    logic [7:0]      plat_cnt_ff;
    logic            plat_run_ff;
    logic            plat_exp_ff;
    // Cache line outputs.
    logic            line_end_ff;
    // Secondary timers.
    logic [7:0]      sec_cnt_ff [NUM_FUNC];
    logic [NUM_FUNC-1:0] sec_run_ff;
    logic [NUM_FUNC-1:0] sec_unc_ff;
    // I/O decode outputs.
    logic            io_valid_ff;
    logic [NUM_FUNC-1:0] io_hit_ff;

    // Address decode.
    wire logic hit_cache = (cfg_req_in.addr == OFF_CACHE);
    wire logic hit_bus   = (cfg_req_in.addr == OFF_BUS);
    wire logic hit_io    = (cfg_req_in.addr == OFF_IO);
    wire logic wr_cache  = cfg_req_in.wr && hit_cache;
    wire logic wr_bus    = cfg_req_in.wr && hit_bus;
    wire logic wr_io     = cfg_req_in.wr && hit_io;

    // Shared field next values; the header type byte at lane 2 is never written.
    wire logic [7:0] nxt_cls  = merge8(cls_ff, wbyte(cfg_req_in.wdata, LANE0),
                                       wr_cache && cfg_req_in.be[LANE0]);
    wire logic [7:0] nxt_plat = merge8(plat_ff, wbyte(cfg_req_in.wdata, LANE1),
                                       wr_cache && cfg_req_in.be[LANE1]);
    wire logic [7:0] nxt_pbus = merge8(pbus_ff, wbyte(cfg_req_in.wdata, LANE0),
                                       wr_bus && cfg_req_in.be[LANE0]);

    // Per-function write and window decode.
    wire logic [31:0] io_bottom [NUM_FUNC];
    wire logic [31:0] io_top    [NUM_FUNC];
    wire logic [NUM_FUNC-1:0] io_hit_now;

    genvar f;
    generate
        for (f = 0; f < NUM_FUNC; f++) begin : g_func
            wire logic sel = (cfg_req_in.func == f[0]);
            wire logic [7:0] nxt_bot_byte = merge8({fregs_ff[f].io_bot_hi, IO_ADDR32_IND},
                                                   wbyte(cfg_req_in.wdata, LANE0),
                                                   sel && wr_io && cfg_req_in.be[LANE0]);
            wire logic [7:0] nxt_top_byte = merge8({fregs_ff[f].io_top_hi, IO_ADDR32_IND},
                                                   wbyte(cfg_req_in.wdata, LANE1),
                                                   sel && wr_io && cfg_req_in.be[LANE1]);
            assign nxt_fregs[f].sec_bus = merge8(fregs_ff[f].sec_bus, wbyte(cfg_req_in.wdata, LANE1),
                                                 sel && wr_bus && cfg_req_in.be[LANE1]);
            assign nxt_fregs[f].sub_bus = merge8(fregs_ff[f].sub_bus, wbyte(cfg_req_in.wdata, LANE2),
                                                 sel && wr_bus && cfg_req_in.be[LANE2]);
            assign nxt_fregs[f].sec_lat = merge8(fregs_ff[f].sec_lat, wbyte(cfg_req_in.wdata, LANE3),
                                                 sel && wr_bus && cfg_req_in.be[LANE3]);
            // Only the upper nibbles are stored; the low nibbles are constants.
            assign nxt_fregs[f].io_bot_hi = nxt_bot_byte[7:4];
            assign nxt_fregs[f].io_top_hi = nxt_top_byte[7:4];
            // Upper halves come from outside; these bytes supply only bits 15:12.
            assign io_bottom[f] = {io_bot_upper_in[f], fregs_ff[f].io_bot_hi, IO_LOW_BOTTOM};
            assign io_top[f]    = {io_top_upper_in[f], fregs_ff[f].io_top_hi, IO_LOW_TOP};
            assign io_hit_now[f] = io_req_in.valid && (io_req_in.addr >= io_bottom[f])
                                   && (io_req_in.addr <= io_top[f]);
        end
    endgenerate

    // Read mux; unmapped offsets and the status half of 1Ch read as zero.
    wire bcb_func_regs_t rsel = fregs_ff[cfg_req_in.func];
    wire logic [7:0] hdr_byte = cfg_req_in.func ? HDR_FUNC1 : HDR_FUNC0;
    wire logic [31:0] rd_cache = {8'h00, hdr_byte, plat_ff, cls_ff};
    wire logic [31:0] rd_bus   = {rsel.sec_lat, rsel.sub_bus, rsel.sec_bus, pbus_ff};
    wire logic [31:0] rd_io    = {16'h0000, rsel.io_top_hi, IO_ADDR32_IND,
                                  rsel.io_bot_hi, IO_ADDR32_IND};
    wire logic [31:0] rd_mux   = hit_cache ? rd_cache :
                                 hit_bus   ? rd_bus   :
                                 hit_io    ? rd_io    : 32'h0000_0000;
    wire logic [31:0] nxt_rd_data = cfg_req_in.rd ? rd_mux : 32'h0000_0000;

    // Cache line boundary; an illegal size disables line ends rather than guessing a length.
    wire logic [7:0] cls_mask  = cls_ff - 8'h01;
    wire logic       cls_legal = (cls_ff != 8'h00) && ((cls_ff & cls_mask) == 8'h00)
                                 && (cls_ff <= CLS_MAX);
    wire logic nxt_line_end = line_idx_valid_in && cls_legal
                              && ((line_idx_in & cls_mask) == cls_mask);

    // Primary latency counter: loads at frame start, counts down while the frame runs.
    wire logic       nxt_plat_run = prim_frame_start_in ? 1'b1 :
                                    (prim_frame_active_in ? plat_run_ff : 1'b0);
    wire logic [7:0] nxt_plat_cnt = prim_frame_start_in ? plat_ff :
                                    ((plat_run_ff && plat_cnt_ff != 8'h00) ?
                                     plat_cnt_ff - 8'h01 : plat_cnt_ff);
    wire logic nxt_plat_exp = plat_run_ff && prim_frame_active_in && !prim_frame_start_in
                              && (plat_cnt_ff == 8'h00);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cls_ff      <= RST_BYTE;
            plat_ff     <= RST_BYTE;
            pbus_ff     <= RST_BYTE;
            rd_data_ff  <= 32'h0000_0000;
            plat_cnt_ff <= RST_BYTE;
            plat_run_ff <= 1'b0;
            plat_exp_ff <= 1'b0;
            line_end_ff <= 1'b0;
            io_valid_ff <= 1'b0;
            io_hit_ff   <= '0;
        end else begin
            cls_ff      <= nxt_cls;
            plat_ff     <= nxt_plat;
            pbus_ff     <= nxt_pbus;
            rd_data_ff  <= nxt_rd_data;
            plat_cnt_ff <= nxt_plat_cnt;
            plat_run_ff <= nxt_plat_run;
            plat_exp_ff <= nxt_plat_exp;
            line_end_ff <= nxt_line_end;
            io_valid_ff <= io_req_in.valid;
            io_hit_ff   <= io_hit_now;
        end
    end

    // Per-function storage and unclaimed-access timers.
    generate
        for (f = 0; f < NUM_FUNC; f++) begin : g_state
            wire logic claimed = sec_claimed_in[f];
            wire logic at_lim  = (sec_cnt_ff[f] == fregs_ff[f].sec_lat);
            wire logic nxt_run = sec_access_start_in[f] ? 1'b1 :
                                 ((claimed || at_lim) ? 1'b0 : sec_run_ff[f]);
            wire logic [7:0] nxt_cnt = sec_access_start_in[f] ? 8'h00 :
                                       (sec_run_ff[f] ? sec_cnt_ff[f] + 8'h01 : sec_cnt_ff[f]);
            wire logic nxt_unc = sec_run_ff[f] && !sec_access_start_in[f] && !claimed && at_lim;
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    fregs_ff[f]   <= '{RST_BYTE, RST_BYTE, RST_BYTE, RST_NIB, RST_NIB};
                    sec_cnt_ff[f] <= RST_BYTE;
                    sec_run_ff[f] <= 1'b0;
                    sec_unc_ff[f] <= 1'b0;
                end else begin
                    fregs_ff[f]   <= nxt_fregs[f];
                    sec_cnt_ff[f] <= nxt_cnt;
                    sec_run_ff[f] <= nxt_run;
                    sec_unc_ff[f] <= nxt_unc;
                end
            end
        end
    endgenerate

    // Outputs straight from flip-flops.
    assign cfg_rdata_out        = rd_data_ff;
    assign line_end_out         = line_end_ff;
    assign prefetch_dwords_out  = cls_ff;
    assign prim_lat_expired_out = plat_exp_ff;
    assign sec_unclaimed_out    = sec_unc_ff;
    assign io_dec_valid_out     = io_valid_ff;
    assign io_in_window_out     = io_hit_ff;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    hdr_func0_type_a: assert property (cfg_req_in.rd && hit_cache && !cfg_req_in.func
        |=> cfg_rdata_out[23:16] == 8'h81)
        else $error("Function 0 header type is not 81h.");

    hdr_func1_type_a: assert property (cfg_req_in.rd && hit_cache && cfg_req_in.func
        |=> cfg_rdata_out[23:16] == 8'h01)
        else $error("Function 1 header type is not 01h.");

    io_indicator_read_a: assert property (cfg_req_in.rd && hit_io
        |=> cfg_rdata_out[3:0] == 4'h1 && cfg_rdata_out[11:8] == 4'h1 && cfg_rdata_out[31:16] == 16'h0000)
        else $error("I/O addressing indicator nibbles are wrong.");

    pbus_write_read_a: assert property (wr_bus && cfg_req_in.be[0] ##1 cfg_req_in.rd && hit_bus
        |=> cfg_rdata_out[7:0] == $past(cfg_req_in.wdata[7:0], 2))
        else $error("Primary bus number did not read back.");

    func_isolation_a: assert property (cfg_req_in.wr && !cfg_req_in.func
        |=> fregs_ff[1] == $past(fregs_ff[1]))
        else $error("Write to function 0 changed function 1 fields.");

    io_window_bottom_a: assert property (io_req_in.valid && io_req_in.addr == io_bottom[0]
        && io_bottom[0] <= io_top[0] |=> io_in_window_out[0] && io_dec_valid_out)
        else $error("Window bottom address not forwarded.");

    io_window_top_a: assert property (io_req_in.valid && io_req_in.addr == io_top[1]
        && io_bottom[1] <= io_top[1] |=> io_in_window_out[1])
        else $error("Window top address not forwarded.");

    io_window_below_a: assert property (io_req_in.valid && io_req_in.addr < io_bottom[0]
        |=> !io_in_window_out[0])
        else $error("Address below window was forwarded.");

    prim_lat_zero_a: assert property (prim_frame_start_in && plat_ff == 8'h00
        ##1 (prim_frame_active_in && !prim_frame_start_in) |=> prim_lat_expired_out)
        else $error("Primary latency of zero did not expire after one clock.");

    prim_lat_early_a: assert property (prim_frame_start_in && plat_ff == 8'h03
        ##1 (prim_frame_active_in && !prim_frame_start_in)[*3] |=> !prim_lat_expired_out)
        else $error("Primary latency expired too early.");

    sec_unclaimed_a: assert property (sec_access_start_in[0] && fregs_ff[0].sec_lat == 8'h02
        ##1 (!sec_claimed_in[0] && !sec_access_start_in[0] && $stable(fregs_ff[0].sec_lat))[*3]
        |=> sec_unclaimed_out[0])
        else $error("Unclaimed secondary access not flagged after the latency.");

    sec_claimed_a: assert property (sec_claimed_in[0] && !sec_access_start_in[0]
        |=> !sec_unclaimed_out[0])
        else $error("Claimed access flagged as unclaimed.");

    line_end_four_a: assert property (line_idx_valid_in && cls_ff == 8'h04 && line_idx_in[1:0] == 2'b11
        |=> line_end_out)
        else $error("Line end missed for a four-dword line.");

    line_illegal_a: assert property (line_idx_valid_in && cls_ff == 8'h03
        |=> !line_end_out)
        else $error("Illegal cache line size produced a line end.");

    // Field write paths: each enabled lane of a writable field lands at the next edge; the header word's top byte reads zero.
    cls_write_a: assert property (wr_cache && cfg_req_in.be[0]
        |=> prefetch_dwords_out == $past(cfg_req_in.wdata[7:0]))
        else $error("Cache line size write did not land.");

    plat_write_a: assert property (wr_cache && cfg_req_in.be[1]
        |=> plat_ff == $past(cfg_req_in.wdata[15:8]))
        else $error("Primary latency write did not land.");

    hdr_upper_zero_a: assert property (cfg_req_in.rd && hit_cache
        |=> cfg_rdata_out[31:24] == 8'h00)
        else $error("Top byte of the header word is not zero.");

    pbus_write_a: assert property (wr_bus && cfg_req_in.be[0]
        |=> pbus_ff == $past(cfg_req_in.wdata[7:0]))
        else $error("Primary bus number write did not land.");

    sec_bus0_write_a: assert property (wr_bus && cfg_req_in.be[1] && !cfg_req_in.func
        |=> fregs_ff[0].sec_bus == $past(cfg_req_in.wdata[15:8]))
        else $error("Function 0 secondary bus write did not land.");

    sec_bus1_write_a: assert property (wr_bus && cfg_req_in.be[1] && cfg_req_in.func
        |=> fregs_ff[1].sec_bus == $past(cfg_req_in.wdata[15:8]))
        else $error("Function 1 secondary bus write did not land.");

    sub_bus0_write_a: assert property (wr_bus && cfg_req_in.be[2] && !cfg_req_in.func
        |=> fregs_ff[0].sub_bus == $past(cfg_req_in.wdata[23:16]))
        else $error("Function 0 subordinate bus write did not land.");

    sub_bus1_write_a: assert property (wr_bus && cfg_req_in.be[2] && cfg_req_in.func
        |=> fregs_ff[1].sub_bus == $past(cfg_req_in.wdata[23:16]))
        else $error("Function 1 subordinate bus write did not land.");

    sec_lat0_write_a: assert property (wr_bus && cfg_req_in.be[3] && !cfg_req_in.func
        |=> fregs_ff[0].sec_lat == $past(cfg_req_in.wdata[31:24]))
        else $error("Function 0 secondary latency write did not land.");

    sec_lat1_write_a: assert property (wr_bus && cfg_req_in.be[3] && cfg_req_in.func
        |=> fregs_ff[1].sec_lat == $past(cfg_req_in.wdata[31:24]))
        else $error("Function 1 secondary latency write did not land.");

    io_bot_write_a: assert property (wr_io && cfg_req_in.be[0] && !cfg_req_in.func
        |=> fregs_ff[0].io_bot_hi == $past(cfg_req_in.wdata[7:4]))
        else $error("I/O base nibble write did not land.");

    io_top_write_a: assert property (wr_io && cfg_req_in.be[1] && !cfg_req_in.func
        |=> fregs_ff[0].io_top_hi == $past(cfg_req_in.wdata[15:12]))
        else $error("I/O limit nibble write did not land.");

    func1_isolation_a: assert property (cfg_req_in.wr && cfg_req_in.func
        |=> fregs_ff[0] == $past(fregs_ff[0]))
        else $error("Write to function 1 changed function 0 fields.");

    // Window decode, timer and line end outputs.
    io_upper_miss_a: assert property (io_req_in.valid && io_bot_upper_in[0] == io_top_upper_in[0]
        && io_req_in.addr[31:16] != io_bot_upper_in[0] |=> !io_in_window_out[0])
        else $error("Address outside the upper window half was forwarded.");

    io_above_top_a: assert property (io_req_in.valid && io_req_in.addr > io_top[1]
        |=> !io_in_window_out[1])
        else $error("Address above window was forwarded.");

    io_valid_follow_a: assert property (io_req_in.valid
        |=> io_dec_valid_out)
        else $error("Decode valid did not follow the request.");

    io_idle_quiet_a: assert property (!io_req_in.valid
        |=> !io_dec_valid_out && io_in_window_out == '0)
        else $error("Decode outputs active without a request.");

    prim_lat_drop_a: assert property (!prim_frame_active_in
        |=> !prim_lat_expired_out)
        else $error("Primary latency expiry outside a frame.");

    line_needs_valid_a: assert property (!line_idx_valid_in
        |=> !line_end_out)
        else $error("Line end without a valid index.");

    cov_io_hit_c: cover property (io_req_in.valid ##1 io_in_window_out[1]);
    cov_sec_timeout_c: cover property (sec_access_start_in[1] ##[1:20] sec_unclaimed_out[1]);
    cov_prim_expire_c: cover property (prim_frame_start_in ##[1:20] prim_lat_expired_out);
    cov_func1_write_c: cover property (wr_bus && cfg_req_in.func ##1 cfg_req_in.rd && hit_bus);

endmodule : bcb_cfg_regs

// ---- hw/bcb_pkg.sv ----
// Constants, field layouts and carrier types of the bridge configuration header bank.
// Assumes one PCI clock domain and a configuration master that uses the plain register port.
package bcb_pkg;

    // Secondary functions, each with its own header register set.
    localparam int NUM_FUNC = 2;

    // Dword byte addresses of the covered header words.
    localparam logic [7:0] OFF_CACHE = 8'h0c;
    localparam logic [7:0] OFF_BUS   = 8'h18;
    localparam logic [7:0] OFF_IO    = 8'h1c;

    // Byte lanes inside a dword.
    localparam int LANE0 = 0;
    localparam int LANE1 = 1;
    localparam int LANE2 = 2;
    localparam int LANE3 = 3;

    // Read-only values.
    localparam logic [7:0] HDR_FUNC0     = 8'h81;
    localparam logic [7:0] HDR_FUNC1     = 8'h01;
    localparam logic [3:0] IO_ADDR32_IND = 4'h1;

    // Largest cache line size that the line logic accepts, in dwords.
    localparam logic [7:0] CLS_MAX = 8'h10;

    // Implied low bits of the I/O window bounds.
    localparam logic [11:0] IO_LOW_BOTTOM = 12'h000;
    localparam logic [11:0] IO_LOW_TOP    = 12'hfff;

    // Reset values of writable fields.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB  = 4'h0;

    // Per-function writable fields.
    typedef struct packed {
        logic [7:0] sub_bus;
        logic [7:0] sec_bus;
        logic [7:0] sec_lat;
        logic [3:0] io_bot_hi;
        logic [3:0] io_top_hi;
    } bcb_func_regs_t;

    // One configuration access from the primary-side master.
    typedef struct packed {
        logic [7:0]  addr;
        logic        func;
        logic [3:0]  be;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bcb_cfg_req_t;

    // One I/O address presented for a forwarding decision.
    typedef struct packed {
        logic [31:0] addr;
        logic        valid;
    } bcb_io_req_t;

endpackage : bcb_pkg

// ---- test/bcb_cfg_master.sv ----
// Configuration master model that issues single-cycle reads and writes to the header bank.
// Assumes the bank answers a read in the next cycle and never stalls.
`timescale 1ns/1ns

module bcb_cfg_master
    import bcb_pkg::*;
(
    // Clock and read answer.
    input  wire logic        clk_in,
    input  wire logic [31:0] rdata_in,
    // Request to the bank.
    output bcb_cfg_req_t     req_out
);
    initial req_out = '0;

    // Idle address and data are inverted so that a stale request never looks like a fresh one.
    task automatic access(input logic w, input logic f, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d, output logic [31:0] q);
        logic [3:0] be_ok;
        be_ok = be;
        if (w && a == OFF_CACHE && (d[7:0] > CLS_MAX || $countones(d[7:0]) > 1)) begin
            be_ok[0] = 1'b0;
        end
        @(posedge clk_in);
        req_out <= '{addr: a, func: f, be: be_ok, wdata: d, wr: w, rd: !w};
        @(posedge clk_in);
        req_out <= '{addr: ~a, func: f, be: 4'h0, wdata: ~d, wr: 1'b0, rd: 1'b0};
        #1 q = rdata_in;
    endtask : access
endmodule : bcb_cfg_master

// ---- test/tb_bcb_cfg_regs.sv ----
// Self-checking bench for the bridge header bank: registers, timers and I/O window decode.
// Assumes one 100 MHz clock and the configuration master model beside it.
`timescale 1ns/1ns

module tb_bcb_cfg_regs
    import bcb_pkg::*;
;
    logic                clk_in = 1'b0;
    logic                rst_n_in;
    bcb_cfg_req_t        req;
    logic [31:0]         rdata, q;
    logic                idx_v, line_end, fstart, factive, pexp, dv;
    logic [7:0]          idx, pref;
    logic [NUM_FUNC-1:0] sstart, sclaim, sunc, inwin;
    logic [15:0]         bup [NUM_FUNC];
    logic [15:0]         tup [NUM_FUNC];
    bcb_io_req_t         ioq;
    int                  num_errors = 0;
    int                  n_tests = 0;
    int                  cycles = 0;
    logic [7:0]          lidx [4] = '{8'h07, 8'h08, 8'h0f, 8'h03};
    logic                lend [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [31:0]         wa [6] = '{32'h0001_1fff, 32'h0001_2000, 32'h0001_5fff, 32'h0001_6000,
                                    32'h0002_0fff, 32'h0002_1000};
    logic [1:0]          wexp [6] = '{2'b00, 2'b01, 2'b01, 2'b00, 2'b10, 2'b00};

    always #5 clk_in = ~clk_in;

    bcb_cfg_master m (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));

    bcb_cfg_regs uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_req_in(req), .cfg_rdata_out(rdata),
        .line_idx_valid_in(idx_v), .line_idx_in(idx), .line_end_out(line_end), .prefetch_dwords_out(pref),
        .prim_frame_start_in(fstart), .prim_frame_active_in(factive), .prim_lat_expired_out(pexp),
        .sec_access_start_in(sstart), .sec_claimed_in(sclaim), .sec_unclaimed_out(sunc),
        .io_bot_upper_in(bup), .io_top_upper_in(tup), .io_req_in(ioq),
        .io_dec_valid_out(dv), .io_in_window_out(inwin));

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: flags %b, expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        m.access(1'b1, f, a, be, d, q);
    endtask : wr

    task automatic rd(input logic f, input logic [7:0] a, input logic [31:0] exp);
        m.access(1'b0, f, a, 4'h0, 32'h0, q);
        chk_word(q, exp);
    endtask : rd

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // The whole run needs well under a thousand cycles.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("wrong value at %0t: run timed out", $time);
            conclude();
        end
    end

    initial begin
        rst_n_in = 1'b0; idx_v = 1'b0; idx = 8'h00; fstart = 1'b0; factive = 1'b0;
        sstart = '0; sclaim = '0; ioq = '0;
        bup = '{16'h0001, 16'h0002};
        tup = '{16'h0001, 16'h0002};
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(1'b0, OFF_CACHE, 32'h0081_0000);
        rd(1'b1, OFF_CACHE, 32'h0001_0000);
        rd(1'b1, OFF_BUS, 32'h0000_0000);
        rd(1'b0, OFF_IO, 32'h0000_0101);
        $display("reset values done");
        wr(1'b0, OFF_CACHE, 4'hf, 32'hffff_0308);
        rd(1'b0, OFF_CACHE, 32'h0081_0308);
        rd(1'b1, OFF_CACHE, 32'h0001_0308);
        chk_word({24'h0, pref}, 32'h0000_0008);
        foreach (lidx[i]) begin
            @(posedge clk_in);
            idx_v <= 1'b1;
            idx <= lidx[i];
            @(posedge clk_in);
            idx_v <= 1'b0;
            #1 chk_flag({1'b0, line_end}, {1'b0, lend[i]});
        end
        @(posedge clk_in);
        fstart <= 1'b1;
        factive <= 1'b1;
        @(posedge clk_in);
        fstart <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1 chk_flag({1'b0, pexp}, 2'b00);
        @(posedge clk_in);
        #1 chk_flag({1'b0, pexp}, 2'b01);
        @(posedge clk_in);
        factive <= 1'b0;
        @(posedge clk_in);
        #1 chk_flag({1'b0, pexp}, 2'b00);
        $display("cache line and primary timer done");
        wr(1'b0, OFF_BUS, 4'hf, 32'h0333_2211);
        wr(1'b1, OFF_BUS, 4'hf, 32'h0388_6655);
        rd(1'b0, OFF_BUS, 32'h0333_2255);
        rd(1'b1, OFF_BUS, 32'h0388_6655);
        wr(1'b0, OFF_BUS, 4'h2, 32'h0000_aa00);
        rd(1'b0, OFF_BUS, 32'h0333_aa55);
        // Both functions have a latency of three; only the unclaimed one reports, four clocks after the start.
        @(posedge clk_in);
        sstart <= 2'b11;
        sclaim <= 2'b01;
        @(posedge clk_in);
        sstart <= 2'b00;
        repeat (3) @(posedge clk_in);
        #1 chk_flag(sunc, 2'b00);
        @(posedge clk_in);
        #1 chk_flag(sunc, 2'b10);
        sclaim <= 2'b00;
        $display("bus numbers and secondary timer done");
        wr(1'b0, OFF_IO, 4'hf, 32'hffff_5f2f);
        rd(1'b0, OFF_IO, 32'h0000_5121);
        rd(1'b1, OFF_IO, 32'h0000_0101);
        foreach (wa[i]) begin
            @(posedge clk_in);
            ioq <= '{addr: wa[i], valid: 1'b1};
            @(posedge clk_in);
            ioq <= '{addr: ~wa[i], valid: 1'b0};
            #1 chk_flag(inwin, wexp[i]);
            chk_flag({1'b0, dv}, 2'b01);
        end
        $display("I/O window done");
        wr(1'b0, 8'h10, 4'hf, 32'hffff_ffff);
        rd(1'b0, 8'h10, 32'h0000_0000);
        wr(1'b1, OFF_CACHE, 4'hc, 32'hffff_ffff);
        rd(1'b1, OFF_CACHE, 32'h0001_0308);
        @(posedge clk_in);
        #1 chk_word(rdata, 32'h0000_0000);
        $display("unmapped and read-only access done");
        conclude();
    end
endmodule : tb_bcb_cfg_regs
